/* hw/vf_consts.svh */
`ifndef VF_CONSTS_SVH
`define VF_CONSTS_SVH

// load port word addresses
`define VF_ADDR_CFG0        12'h200
`define VF_ADDR_CFG1        12'h201
`define VF_ADDR_CFG2        12'h202
`define VF_ADDR_CFG3        12'h203
`define VF_ADDR_CFG4        12'h204
`define VF_ADDR_CFG5        12'h205
`define VF_ADDR_STATUS      12'h206
`define VF_ADDR_SEL_BASE    12'h600
`define VF_ADDR_RND_BASE    12'ha00
`define VF_ADDR_LIM_BASE    12'he00

// configuration field positions
`define VF_CFG0_ALU_SUB     0
`define VF_CFG0_PASS_A      1
`define VF_CFG0_PASS_B      2
`define VF_CFG1_ODD_ILV     0
`define VF_CFG1_IDLEN_LO    1
`define VF_CFG1_IDLEN_HI    4
`define VF_CFG1_ODD_TAPS    5
`define VF_CFG1_REV_OFF     6
`define VF_CFG3_RECIRC      0
`define VF_CFG3_PAR_LOAD    1
`define VF_CFG4_SEPARATE    0
`define VF_CFG5_VLIM_EN     0
`define VF_LIM_LO_HI        11
`define VF_LIM_UP_LO        12
`define VF_LIM_UP_HI        23

// reset values and counts
`define VF_CFG_RESET        12'h000
`define VF_LB_MIN_LEN       12'h004
`define VF_LB_MAX_LEN       3076
`define VF_SEL_MAX          5'h14

`endif

/* hw/vf_pkg.sv */
package vf_pkg;

	// load port request: word address and data
	typedef struct packed {
		logic [11:0] addr;
		logic [31:0] data;
	} vf_load_s;

	// decoded words for the horizontal path
	typedef struct packed {
		logic       alu_sub;
		logic       pass_a;
		logic       pass_b;
		logic       odd_interleave;
		logic [4:0] id_length;
		logic       odd_taps;
		logic       reversal_en;
	} vf_hcfg_s;

	// line buffer operating mode
	typedef enum logic { VF_LB_DELAY, VF_LB_RECIRC } vf_lb_mode_e;

endpackage : vf_pkg

/* hw/vf_filter.sv */
`timescale 1ns/1ns
`include "vf_consts.svh"

// small synchronous fifo, valid/ready on both sides
module vf_fifo #(
	parameter int W = 12,
	parameter int D = 8
) (
	// clock and reset
	input  wire logic         ref_clk,
	input  wire logic         rst_n,
	// fill side
	input  wire logic         in_valid,
	output logic              in_ready,
	input  wire logic [W-1:0] in_data,
	// drain side
	output logic              out_valid,
	input  wire logic         out_ready,
	output logic [W-1:0]      out_data,
	// fill level
	output logic [$clog2(D):0] level
);
	localparam int AW = $clog2(D);

	logic [W-1:0] mem [D];
	logic [AW:0]  wr_q;
	logic [AW:0]  rd_q;
	wire          push = in_valid & in_ready;
	wire          pop  = out_valid & out_ready;

	// pointers carry one extra bit so full and empty differ
	assign level     = wr_q - rd_q;
	assign in_ready  = (level != (AW+1)'(D));
	assign out_valid = (level != '0);
	assign out_data  = mem[rd_q[AW-1:0]];

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			wr_q <= '0;
			rd_q <= '0;
		end else begin
			if (push) wr_q <= wr_q + 1'b1;
			if (pop) rd_q <= rd_q + 1'b1;
		end
	end

	// storage is not reset; the pointers guard it
	always_ff @(posedge ref_clk) begin
		if (push) mem[wr_q[AW-1:0]] <= in_data;
	end
endmodule : vf_fifo

// Overview of operation
// [RULE1] cfg0 bit0 add/subtract, bit1 gates input A
// [RULE2] cfg0 bit2 gates ALU input B
// [RULE3] cfg1 bit0 enables odd-tap interleave
// [RULE4] cfg1 bits4-1 give stage length plus one
// [RULE5] cfg1 bit5 selects even or odd taps
// [RULE6] cfg1 bit6 low enables data reversal
// [RULE7] vertical FIR with up to eight taps
// [RULE8] seven buffers delay line length plus four
// [RULE9] host keeps line length at most 3072
// [RULE10] cfg3 bit0 selects delay or recirculate
// [RULE11] cfg3 bit1 loads all buffers in parallel
// [RULE12] vertical enable gates buffers, more when orthogonal
// [RULE13] orthogonal mode needs both enables to load
// [RULE14] interleaved lines up to 3076 values work
// [RULE15] add selected 32-bit round register
// [RULE16] select index picks round/select/limit per cycle
// [RULE17] select register picks 12-bit output window
// [RULE18] limiting only when cfg5 bit0 set
// [RULE19] sixteen 24-bit limit registers by index
// [RULE20] clamp below lower, above upper bound
// [RULE21] host programs upper above lower bound
// [RULE22] lower bound bits 11-0, upper 23-12
// [RULE23] select registers are five bits wide
// [RULE24] cfg4 bit0 orthogonal or separate mode
// [RULE25] round, window, limit, one registered sample
// [RULE26] host writes reserved bits as zero
module vf_filter import vf_pkg::*; #(
	parameter int TAPS     = 8,
	parameter int NBUF     = 7,
	parameter int LB_DEPTH = `VF_LB_MAX_LEN,
	parameter int FIFO_D   = 8
) (
	// clock and reset
	input  wire logic                 ref_clk,
	input  wire logic                 rst_n,
	// pixel source
	input  wire logic [11:0]          pixel_input_bus,
	input  wire logic                 horizontal_shift_enable,
	input  wire logic                 vertical_shift_enable,
	input  wire logic [3:0]           vertical_register_select_index,
	output logic                      pixel_ready,
	// coefficients from the bank logic
	input  wire logic [TAPS-1:0][11:0] vertical_coeffs,
	// register load and read port
	input  wire logic                 load_strobe,
	input  wire vf_load_s             load_req,
	input  wire logic [11:0]          read_addr,
	output logic [31:0]               read_data,
	// horizontal path configuration and ALU
	output vf_hcfg_s                  hcfg,
	output logic                      id_shift_enable,
	input  wire logic [11:0]          alu_fwd_data,
	input  wire logic [11:0]          alu_rev_data,
	output logic [12:0]               alu_result,
	// vertical output stream
	output logic                      vout_valid,
	input  wire logic                 vout_ready,
	output logic [11:0]               vout_data
);
	localparam int LW = $clog2(LB_DEPTH);

	// configuration and control storage
	logic [11:0] cfg_q [6];
	logic [31:0] rnd_q [16];
	logic [4:0]  sel_q [16];
	logic [23:0] lim_q [16];

	// decoded load targets
	wire [11:0] la       = load_req.addr;
	wire        ld_cfg   = load_strobe & (la[11:4] == `VF_ADDR_CFG0 >> 4) & (la[3:0] < 4'h6);
	wire        ld_sel   = load_strobe & (la[11:4] == `VF_ADDR_SEL_BASE >> 4);
	wire        ld_rnd   = load_strobe & (la[11:4] == `VF_ADDR_RND_BASE >> 4);
	wire        ld_lim   = load_strobe & (la[11:4] == `VF_ADDR_LIM_BASE >> 4);

	// mode decode
	wire separate  = cfg_q[4][`VF_CFG4_SEPARATE];                             // RULE24
	wire both_en   = horizontal_shift_enable & vertical_shift_enable;
	vf_lb_mode_e lb_mode;
	assign lb_mode = cfg_q[3][`VF_CFG3_RECIRC] ? VF_LB_RECIRC : VF_LB_DELAY;   // RULE10
	wire par_load  = cfg_q[3][`VF_CFG3_PAR_LOAD];

	// reserved bits are stored but drive nothing
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			for (int i = 0; i < 6; i++) cfg_q[i] <= `VF_CFG_RESET;
		end else if (ld_cfg) begin
			cfg_q[la[2:0]] <= load_req.data[11:0];
		end
	end

	// control banks; contents undefined until loaded
	always_ff @(posedge ref_clk) begin
		if (ld_sel) sel_q[la[3:0]] <= load_req.data[4:0];                      // RULE23
		if (ld_rnd) rnd_q[la[3:0]] <= load_req.data;
		if (ld_lim) lim_q[la[3:0]] <= load_req.data[23:0];                     // RULE19
	end

	// horizontal path configuration words, one driver for the whole struct
	assign hcfg = '{
		alu_sub:        cfg_q[0][`VF_CFG0_ALU_SUB],                          // RULE1
		pass_a:         cfg_q[0][`VF_CFG0_PASS_A],                           // RULE1
		pass_b:         cfg_q[0][`VF_CFG0_PASS_B],                           // RULE2
		odd_interleave: cfg_q[1][`VF_CFG1_ODD_ILV],                          // RULE3
		id_length:      {1'b0, cfg_q[1][`VF_CFG1_IDLEN_HI:`VF_CFG1_IDLEN_LO]} + 5'h01, // RULE4
		odd_taps:       cfg_q[1][`VF_CFG1_ODD_TAPS],                         // RULE5
		reversal_en:    ~cfg_q[1][`VF_CFG1_REV_OFF]                          // RULE6
	};

	// ALU: zero-forced inputs, add or B minus A
	wire signed [12:0] alu_a = hcfg.pass_a ? 13'(signed'(alu_fwd_data)) : 13'h0000; // RULE1
	wire signed [12:0] alu_b = hcfg.pass_b ? 13'(signed'(alu_rev_data)) : 13'h0000; // RULE2
	wire signed [12:0] alu_d = hcfg.alu_sub ? (alu_b - alu_a) : (alu_a + alu_b);    // RULE1

	always_ff @(posedge ref_clk) begin
		if (!rst_n) alu_result <= '0;
		else alu_result <= alu_d;
	end

	// pipeline advances only while the output slot can drain
	logic        fifo_in_ready;
	logic        v1_q;
	logic        v2_q;
	wire         adv = ~v2_q | fifo_in_ready;
	assign pixel_ready = adv;

	// shift enable gating: orthogonal needs both enables
	wire in_en = (separate ? 1'b1 : both_en) & adv;                            // RULE12 RULE13
	wire lb_en = (separate ? vertical_shift_enable : both_en) & adv;          // RULE12 RULE13
	assign id_shift_enable = separate ? horizontal_shift_enable : both_en;    // RULE13

	// input register; valid flag and index ride with the pixel so the
	// output stage applies the entry chosen in the pixel's own cycle
	logic [11:0] din_q;
	logic        din_v_q;
	logic [3:0]  din_idx_q;
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			din_q     <= '0;
			din_v_q   <= 1'b0;
			din_idx_q <= '0;
		end else if (adv) begin
			din_v_q <= in_en;
			if (in_en) din_q <= pixel_input_bus;
			if (in_en) din_idx_q <= vertical_register_select_index;   // RULE16
		end
	end

	// shared ring pointer; delay equals line length plus four
	// one spare bit so a length equal to the ring depth does not wrap to zero
	logic [LW-1:0] ptr_q;
	wire  [LW:0]   lb_len   = (LW+1)'(cfg_q[2]) + (LW+1)'(`VF_LB_MIN_LEN);   // RULE8 RULE9
	wire           ptr_wrap = ({1'b0, ptr_q} >= lb_len - 1'b1);              // RULE8
	always_ff @(posedge ref_clk) begin
		if (!rst_n) ptr_q <= '0;
		else if (lb_en) ptr_q <= ptr_wrap ? '0 : ptr_q + 1'b1;               // RULE8
	end

	// taps: input register then each buffer output
	logic [11:0] tap [TAPS];
	assign tap[0] = din_q;

	// line buffers; interleaved lines just need to fit the ring
	for (genvar k = 0; k < NBUF; k++) begin : g_lb
		logic [11:0] ram [LB_DEPTH];
		wire  [11:0] rd_word = ram[ptr_q];
		wire  [11:0] wr_word = par_load ? din_q :                               // RULE11
		                       (lb_mode == VF_LB_RECIRC) ? rd_word : tap[k];  // RULE10 RULE14
		assign tap[k+1] = rd_word;
		always_ff @(posedge ref_clk) begin
			if (lb_en) ram[ptr_q] <= wr_word;                                  // RULE12
		end
	end

	// eight-tap sum of products
	logic signed [31:0] sum;
	always_comb begin
		sum = '0;
		for (int t = 0; t < TAPS; t++)
			sum = sum + 32'(signed'(tap[t]) * signed'(vertical_coeffs[t]));   // RULE7
	end

	// stage 1: filter result and its index
	logic [31:0] acc_q;
	logic [3:0]  idx_q;
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			acc_q <= '0;
			idx_q <= '0;
			v1_q  <= 1'b0;
		end else if (adv) begin
			acc_q <= sum;
			idx_q <= din_idx_q;                                               // RULE16
			v1_q  <= din_v_q;
		end
	end

	// output stage: round, window, limit
	wire [31:0] rnd_sum = acc_q + rnd_q[idx_q];                                // RULE15 RULE16
	wire [4:0]  sel_raw = sel_q[idx_q];                                        // RULE16
	wire [4:0]  sel_pos = (sel_raw > `VF_SEL_MAX) ? `VF_SEL_MAX : sel_raw;    // out-of-range clamps
	wire [11:0] window  = rnd_sum[sel_pos +: 12];                              // RULE17
	wire [23:0] lim     = lim_q[idx_q];                                        // RULE16
	wire signed [11:0] lo = lim[`VF_LIM_LO_HI:0];                              // RULE22
	wire signed [11:0] up = lim[`VF_LIM_UP_HI:`VF_LIM_UP_LO];                  // RULE22
	wire signed [11:0] w_s = window;
	// signed compares; bounds assumed ordered by the host
	wire        below_lo = (w_s < lo);                                         // RULE20
	wire        above_up = (w_s > up);                                         // RULE20
	wire [11:0] clamped  = below_lo ? lo : above_up ? up : window;             // RULE20 RULE21
	wire [11:0] final_w = cfg_q[5][`VF_CFG5_VLIM_EN] ? clamped : window;       // RULE18

	logic [11:0] res_q;
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			res_q <= '0;
			v2_q  <= 1'b0;
		end else if (adv) begin
			res_q <= final_w;                                                   // RULE25
			v2_q  <= v1_q;
		end
	end

	// output buffer; a stalled sink backs up into the pipeline
	logic [$clog2(FIFO_D):0] fifo_level;
	vf_fifo #(.W(12), .D(FIFO_D)) u_fifo (
		.ref_clk   (ref_clk),
		.rst_n     (rst_n),
		.in_valid  (v2_q),
		.in_ready  (fifo_in_ready),
		.in_data   (res_q),
		.out_valid (vout_valid),
		.out_ready (vout_ready),
		.out_data  (vout_data),
		.level     (fifo_level)
	);

	// readback, one cycle after the address
	wire [31:0] status_w = {22'h0, fifo_level[3:0], lb_mode, separate, v2_q, v1_q,
	                        fifo_in_ready, vout_valid};
	// readback decode; unmapped addresses read as zero
	wire [7:0]  ra_page = read_addr[11:4];
	wire [3:0]  ra_idx  = read_addr[3:0];
	wire        rd_cfg  = (ra_page == 8'(`VF_ADDR_CFG0 >> 4)) & (ra_idx < 4'h6);
	wire        rd_stat = (read_addr == `VF_ADDR_STATUS);
	wire        rd_sel  = (ra_page == 8'(`VF_ADDR_SEL_BASE >> 4));
	wire        rd_rnd  = (ra_page == 8'(`VF_ADDR_RND_BASE >> 4));
	wire        rd_lim  = (ra_page == 8'(`VF_ADDR_LIM_BASE >> 4));
	wire [31:0] rd_d    = rd_cfg  ? {20'h00000, cfg_q[ra_idx[2:0]]} :
	                      rd_stat ? status_w :
	                      rd_sel  ? {27'h0000000, sel_q[ra_idx]} :
	                      rd_rnd  ? rnd_q[ra_idx] :
	                      rd_lim  ? {8'h00, lim_q[ra_idx]} : 32'h0000_0000;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) read_data <= '0;
		else read_data <= rd_d;
	end
endmodule : vf_filter

/* dv/vf_filter_sva.sv */
`timescale 1ns/1ns
// port-level checks; mode shadow mirrors writes of the mode word
module vf_filter_chk import vf_pkg::*; (
	// clock and reset
	input wire logic        ref_clk,
	input wire logic        rst_n,
	// watched ports
	input wire logic        horizontal_shift_enable,
	input wire logic        vertical_shift_enable,
	input wire logic        load_strobe,
	input wire vf_load_s    load_req,
	input wire logic [11:0] read_addr,
	input wire logic [31:0] read_data,
	input wire vf_hcfg_s    hcfg,
	input wire logic        id_shift_enable,
	input wire logic [11:0] alu_fwd_data,
	input wire logic [11:0] alu_rev_data,
	input wire logic [12:0] alu_result,
	input wire logic        vout_valid,
	input wire logic        vout_ready
);
	logic        sep_q;
	logic [12:0] alu_a;
	logic [12:0] alu_b;
	logic [12:0] alu_exp;
	logic [4:0]  idlen_exp;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// alu model, sign extended to the result width
	assign alu_a     = hcfg.pass_a ? {alu_fwd_data[11], alu_fwd_data} : 13'h0000;
	assign alu_b     = hcfg.pass_b ? {alu_rev_data[11], alu_rev_data} : 13'h0000;
	assign alu_exp   = hcfg.alu_sub ? alu_b - alu_a : alu_a + alu_b;
	assign idlen_exp = {1'b0, load_req.data[4:1]} + 5'h01;
	// shadow of the mode bit
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			sep_q <= 1'b0;
		end else if (load_strobe && load_req.addr == 12'h204) begin
			sep_q <= load_req.data[0];
		end
	end
	property p_alu;
		1'b1 |=> alu_result == $past(alu_exp);
	endproperty
	a_alu: assert property (p_alu) else $error("alu result wrong");
	property p_cfg0;
		load_strobe && load_req.addr == 12'h200 |=> hcfg.alu_sub == $past(load_req.data[0])
			&& hcfg.pass_a == $past(load_req.data[1]) && hcfg.pass_b == $past(load_req.data[2]);
	endproperty
	a_cfg0: assert property (p_cfg0) else $error("alu controls wrong");
	property p_cfg1a;
		load_strobe && load_req.addr == 12'h201 |=> hcfg.id_length == $past(idlen_exp)
			&& hcfg.odd_interleave == $past(load_req.data[0]);
	endproperty
	a_cfg1a: assert property (p_cfg1a) else $error("stage length wrong");
	property p_cfg1b;
		load_strobe && load_req.addr == 12'h201 |=> hcfg.odd_taps == $past(load_req.data[5])
			&& hcfg.reversal_en != $past(load_req.data[6]);
	endproperty
	a_cfg1b: assert property (p_cfg1b) else $error("tap or reversal wrong");
	property p_shift;
		id_shift_enable == (horizontal_shift_enable && (sep_q || vertical_shift_enable));
	endproperty
	a_shift: assert property (p_shift) else $error("shift gate wrong");
	property p_rdback;
		load_strobe && load_req.addr == 12'h202 ##2 read_addr == 12'h202
			|=> read_data == {20'h00000, $past(load_req.data[11:0], 3)};
	endproperty
	a_rdback: assert property (p_rdback) else $error("line length readback");
	property p_unmapped;
		read_addr == 12'h207 |=> read_data == 32'h00000000;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_hold;
		vout_valid && !vout_ready |=> vout_valid;
	endproperty
	a_hold: assert property (p_hold) else $error("output dropped");
endmodule : vf_filter_chk

bind vf_filter vf_filter_chk u_chk (.ref_clk(ref_clk), .rst_n(rst_n),
	.horizontal_shift_enable(horizontal_shift_enable), .hcfg(hcfg),
	.vertical_shift_enable(vertical_shift_enable), .load_strobe(load_strobe),
	.load_req(load_req), .read_addr(read_addr), .read_data(read_data),
	.id_shift_enable(id_shift_enable), .alu_fwd_data(alu_fwd_data),
	.alu_rev_data(alu_rev_data), .alu_result(alu_result),
	.vout_valid(vout_valid), .vout_ready(vout_ready));

/* dv/vf_pixel_src.sv */
`timescale 1ns/1ns
// pixel source: entries {h, v, index, pixel}, one per advancing edge
module vf_pixel_src (
	// clock and reset
	input wire logic    ref_clk,
	input wire logic    rst_n,
	// stream to the filter
	input wire logic    pixel_ready,
	output logic [11:0] pixel_input_bus = 12'h000,
	output logic        horizontal_shift_enable = 1'b0,
	output logic        vertical_shift_enable = 1'b0,
	output logic [3:0]  vertical_register_select_index = 4'h0
);
	logic [17:0] pend_q[$];
	logic        busy_q = 1'b0;
	// queued by the bench
	task automatic push(input logic [17:0] ent);
		pend_q.push_back(ent);
	endtask : push
	// hold each entry until pixel_ready; idle bus toggles so stale data never looks valid
	always @(posedge ref_clk) begin
		if (!rst_n || !busy_q || pixel_ready) begin
			if (rst_n && pend_q.size() > 0) begin
				{horizontal_shift_enable, vertical_shift_enable,
					vertical_register_select_index, pixel_input_bus} <= pend_q.pop_front();
				busy_q <= 1'b1;
			end else begin
				horizontal_shift_enable <= 1'b0;
				vertical_shift_enable   <= 1'b0;
				pixel_input_bus         <= ~pixel_input_bus;
				busy_q                  <= 1'b0;
			end
		end
	end
endmodule : vf_pixel_src

/* dv/vf_filter_tb_top.sv */
`timescale 1ns/1ns
module vf_filter_tb_top import vf_pkg::*;;
	logic                 ref_clk = 1'b0;
	logic                 rst_n = 1'b0;
	logic                 load_strobe = 1'b0;
	logic                 vout_ready = 1'b1;
	logic                 pixel_ready, vout_valid, hv, vv;
	logic [3:0]           ix;
	logic [11:0]          pix, vout_data;
	logic [11:0]          read_addr = 12'h000;
	logic [11:0]          af = 12'h005;
	logic [11:0]          ab = 12'h003;
	logic [31:0]          read_data;
	logic [12:0]          alu_result, ea, eb;
	logic [7:0][11:0]     coeffs = {84'h0, 12'h001};
	vf_load_s             load_req = '0;
	vf_hcfg_s             hcfg;
	int                   bad_count = 0;
	int                   n_compared = 0;
	int                   cyc = 0;
	logic [11:0]          got[$];
	logic [11:0]          exp_q[$];
	vf_filter #(.LB_DEPTH(16)) dut (.ref_clk(ref_clk), .rst_n(rst_n), .pixel_input_bus(pix),
		.horizontal_shift_enable(hv), .vertical_shift_enable(vv), .pixel_ready(pixel_ready),
		.vertical_register_select_index(ix), .vertical_coeffs(coeffs),
		.load_strobe(load_strobe), .load_req(load_req), .read_addr(read_addr),
		.read_data(read_data), .hcfg(hcfg), .id_shift_enable(), .alu_fwd_data(af),
		.alu_rev_data(ab), .alu_result(alu_result), .vout_valid(vout_valid),
		.vout_ready(vout_ready), .vout_data(vout_data));
	vf_pixel_src src (.ref_clk(ref_clk), .rst_n(rst_n), .pixel_ready(pixel_ready),
		.pixel_input_bus(pix), .horizontal_shift_enable(hv), .vertical_shift_enable(vv),
		.vertical_register_select_index(ix));
	initial forever #5 ref_clk = ~ref_clk;
	// words leave at the next rising edge, so take them on the falling one
	always @(negedge ref_clk) if (rst_n && vout_valid && vout_ready) got.push_back(vout_data);
	// hang guard
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			bad_count++;
			print_verdict();
		end
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] want);
		n_compared++;
		if (seen !== want) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, want, seen);
		end
	endtask : chk
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		load_strobe <= 1'b1;
		load_req    <= '{addr: a, data: d};
		@(posedge ref_clk);
		load_strobe <= 1'b0;
	endtask : wr
	task automatic rd(input logic [11:0] a, input logic [31:0] e);
		@(posedge ref_clk);
		read_addr <= a;
		@(posedge ref_clk);
		#1 chk("read_data", read_data, e);
	endtask : rd
	// only entries with both enables produce a word
	task automatic px(input logic [1:0] en, input logic [3:0] i, input logic [11:0] p, e);
		src.push({en, i, p});
		if (en == 2'b11) exp_q.push_back(e);
	endtask : px
	task automatic flush();
		for (int i = 0; i < 300 && got.size() < exp_q.size(); i++) @(posedge ref_clk);
		chk("word count", 32'(got.size()), 32'(exp_q.size()));
		while (got.size() > 0 && exp_q.size() > 0) chk("vout_data", got.pop_front(), exp_q.pop_front());
		got.delete();
		exp_q.delete();
	endtask : flush
	task automatic print_verdict();
		if (bad_count == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask : print_verdict
	initial begin
		repeat (20) @(posedge ref_clk);
		rst_n <= 1'b1;
		for (int a = 0; a < 6; a++) rd(12'h200 + 12'(a), 32'h0);
		rd(12'h207, 32'h0);
		chk("hcfg", hcfg, {3'h0, 1'b0, 5'h01, 2'h1});
		wr(12'h201, 32'h07f);
		rd(12'h201, 32'h07f);
		chk("hcfg", hcfg, {3'h0, 1'b1, 5'h10, 2'h2});
		wr(12'h207, 32'hfff);
		wr(12'h201, 32'h000);
		rd(12'h201, 32'h0);
		wr(12'h202, 32'h00c);
		rd(12'h202, 32'h00c);
		wr(12'h202, 32'h000);
		// second half of the sweep uses negative operands to catch sign extension
		for (int c = 0; c < 16; c++) begin
			wr(12'h200, 32'(c % 8));
			af <= c[3] ? 12'hffb : 12'h005;
			ab <= c[3] ? 12'hffd : 12'h003;
			@(posedge ref_clk);
			ea = c[1] ? {af[11], af} : 13'h0000;
			eb = c[2] ? {ab[11], ab} : 13'h0000;
			#1 chk("alu_result", alu_result, 13'(c[0] ? eb - ea : ea + eb));
		end
		// banks: entry 0 narrow limits, 1 round by five, 2 window from bit 4
		wr(12'h600, 32'h0); wr(12'h601, 32'h0); wr(12'h602, 32'h4);
		wr(12'ha00, 32'h0); wr(12'ha01, 32'h5); wr(12'ha02, 32'h0);
		wr(12'he00, 32'h064f9c); wr(12'he01, 32'h7ff800); wr(12'he02, 32'h7ff800);
		// buffers start unknown, so zero all seven at once
		wr(12'h203, 32'h2);
		for (int k = 0; k < 24; k++) src.push(18'h30000);
		for (int i = 0; i < 300 && got.size() < 24; i++) @(posedge ref_clk);
		got.delete();
		wr(12'h203, 32'h0);
		px(2'b11, 4'h0, 12'h7ff, 12'h7ff);
		px(2'b11, 4'h1, 12'h010, 12'h015);
		px(2'b10, 4'h0, 12'h123, 12'h000);
		px(2'b11, 4'h2, 12'h100, 12'h010);
		px(2'b01, 4'h0, 12'h456, 12'h000);
		px(2'b11, 4'h2, 12'hff0, 12'hfff);
		flush();
		wr(12'h205, 32'h1);
		px(2'b11, 4'h0, 12'h7ff, 12'h064);
		px(2'b11, 4'h0, 12'h800, 12'hf9c);
		px(2'b11, 4'h0, 12'h020, 12'h020);
		px(2'b11, 4'h1, 12'h7f0, 12'h7f5);
		flush();
		// stall the sink until the pipe refuses, then drain in order
		@(posedge ref_clk);
		vout_ready <= 1'b0;
		for (int k = 0; k < 16; k++) px(2'b11, 4'h1, 12'(k), 12'(k + 5));
		for (int i = 0; i < 100 && pixel_ready !== 1'b0; i++) @(posedge ref_clk);
		#1 chk("pixel_ready", pixel_ready, 32'h0);
		@(posedge ref_clk);
		vout_ready <= 1'b1;
		flush();
		wr(12'h204, 32'h1);
		rd(12'h204, 32'h1);
		repeat (4) @(posedge ref_clk);
		print_verdict();
	end
endmodule : vf_filter_tb_top
